/* sim/vdram_ctrl_monitor.sv */
`timescale 1ns/1ps
module vdram_ctrl_monitor
	import vdram_ctrl_pkg::*;
(
	// Clock, reset and answer.
	input wire logic              clk_sys,
	input wire logic              resetn,
	input wire logic              rspValid,
	input wire logic              rspRefused,
	// Device pins.
	input wire logic              rasN,
	input wire logic              casN,
	input wire logic              xferOutenN,
	input wire logic              writeMaskWeN,
	input wire logic              specialFunctionSelect,
	input wire logic              shiftClock,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic              dqOe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	logic       colorLoaded;
	logic [8:0] gap;
	// A colour load seen at a row strobe, and cycles since the last row strobe.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			colorLoaded <= 1'b0;
			gap <= 9'h000;
		end else begin
			if ($fell(rasN) && writeMaskWeN && specialFunctionSelect)
				colorLoaded <= 1'b1;
			gap <= $fell(rasN) ? 9'h000 : gap + 9'h001;
		end
	end
	sequence casPulse;
		!casN [*4] ##1 casN;
	endsequence
	sequence maskedRas;
		$fell(rasN) && !writeMaskWeN;
	endsequence
	flash_load_a: assert property ($fell(rasN) && !writeMaskWeN && specialFunctionSelect
		|-> colorLoaded) else $error("flash write before colour load");
	mask_drive_a: assert property (maskedRas |-> dqOe) else $error("mask not driven");
	ras_levels_a: assert property ($fell(rasN) |-> $stable(addr) && $stable(writeMaskWeN)
		&& $stable(xferOutenN)) else $error("levels moved at row strobe");
	cas_pulse_a: assert property ($fell(casN) |-> casPulse) else $error("column pulse");
	cas_in_row_a: assert property ($fell(casN) |-> !rasN) else $error("column outside row");
	refresh_gap_a: assert property (gap < 9'h12c) else $error("refresh too late");
	shift_align_a: assert property (shiftClock |-> $rose(xferOutenN))
		else $error("shift edge");
	// The mask of a masked transfer is driven with the output enable low but the column strobe
	// high; only a column strobe low together with the output enable low lets the device drive.
	drive_idle_a: assert property (dqOe |-> (xferOutenN || casN))
		else $error("drive during output");
	rsp_cas_a: assert property (rspValid |-> casN == rspRefused) else $error("answer timing");
endmodule
bind vdram_ctrl vdram_ctrl_monitor i_vdram_ctrl_monitor (.clk_sys, .resetn, .rspValid,
	.rspRefused, .rasN, .casN, .xferOutenN, .writeMaskWeN, .specialFunctionSelect, .shiftClock,
	.addr, .dqOe);

/* sim/vdram_model.sv */
`timescale 1ns/1ps
module vdram_model
	import vdram_ctrl_pkg::*;
(
	// Levels from the controller.
	input wire logic              rasN,
	input wire logic              casN,
	input wire logic              xferOutenN,
	input wire logic              writeMaskWeN,
	input wire logic              specialFunctionSelect,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] dqOut,
	// Pins driven back.
	output logic [DATA_W-1:0]     dqIn,
	output logic                  activeHalfFlag
);
	bit   [DATA_W-1:0] mem [int];
	bit   [DATA_W-1:0] serial_buffer [int];
	logic [DATA_W-1:0] color;
	logic [DATA_W-1:0] rd = 8'h00;
	logic [DATA_W-1:0] pmask;
	logic [ADDR_W-1:0] row;
	logic              weR;
	logic              dsfR;
	logic              oeR;
	initial activeHalfFlag = 1'b0;
	// Writes one word of the open row under the plane mask.
	task automatic put(input int c, input logic [DATA_W-1:0] d);
		mem[row*512+c] = (mem[row*512+c] & ~pmask) | (d & pmask);
	endtask
	// Row strobe decode.
	// Refresh needs no action here, since the model never loses charge.
	always @(negedge rasN) begin
		row = addr;
		weR = writeMaskWeN;
		dsfR = specialFunctionSelect;
		oeR = xferOutenN;
		pmask = weR ? 8'hff : dqOut;
		if (!weR && dsfR && oeR && casN)
			for (int i = 0; i < ROW_COUNT; i++)
				put(i, color);
	end
	always @(negedge casN) if (!rasN) begin
		if (!oeR) begin
			activeHalfFlag = addr[ADDR_W-1];
			for (int i = 0; i < ROW_COUNT; i++) begin
				if (weR)
					serial_buffer[i] = mem[row*512+i];
				else
					put(i, serial_buffer[i]);
			end
		end else if (dsfR) begin
			if (weR)
				color = dqOut;
		end else if (specialFunctionSelect) begin
			for (int i = 0; i < 4; i++)
				if (dqOut[i])
					put({addr[ADDR_W-1:2], 2'(i)}, color);
		end else if (writeMaskWeN)
			rd = mem[row*512+addr];
		else
			put(addr, dqOut);
	end
	// Data held while the column strobe and output enable are low; a released bus shows the inverse.
	assign dqIn = (!casN && !xferOutenN) ? rd : ~rd;
endmodule

/* sim/video_dram_cycle_decoder_test.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module video_dram_cycle_decoder_test
	import vdram_ctrl_pkg::*;
;
	logic clk_sys = 1'b0;
	logic resetn, cmdValid, cmdReady, rspValid, rspRefused, halfFlag, rRef;
	logic rasN, casN, xferOutenN, writeMaskWeN, specialFunctionSelect, shiftClock, dqOe;
	logic activeHalfFlag;
	cmd_t cmd;
	logic [DATA_W-1:0] rspData, dqOut, dqIn, rData, d, m, e;
	logic [ADDR_W-1:0] addr, r, c, r2;
	int errors, checks, seed, n, cyc;
	bit [DATA_W-1:0] shadow [int];
	always #50 clk_sys = ~clk_sys;
	// Cycles since reset release; the refresh timer of the controller runs in step with it.
	always @(posedge clk_sys) cyc <= resetn ? cyc + 1 : 0;
	vdram_ctrl i_vdram_ctrl (.clk_sys, .resetn, .cmdValid, .cmd, .cmdReady, .rspValid, .rspRefused,
		.rspData, .halfFlag, .rasN, .casN, .xferOutenN, .writeMaskWeN, .specialFunctionSelect,
		.shiftClock, .addr, .dqOut, .dqOe, .dqIn, .activeHalfFlag);
	vdram_model i_vdram_model (.rasN, .casN, .xferOutenN, .writeMaskWeN, .specialFunctionSelect,
		.addr, .dqOut, .dqIn, .activeHalfFlag);
	// Expected word after a write under a plane mask.
	function automatic void put(int rr, int cc, logic [7:0] dd, mm);
		shadow[rr*512+cc] = (shadow[rr*512+cc] & ~mm) | (dd & mm);
	endfunction
	task automatic test_done;
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// One request: held until taken, then its answer is awaited.
	task automatic go(op_t o, logic [8:0] rr, cc, logic [7:0] dd, mm, logic k, x);
		@(negedge clk_sys);
		cmdValid = 1'b1;
		cmd = {o, rr, cc, dd, mm, k};
		n = 0;
		// Ready is looked at half a cycle before the edge that takes the request.
		while (cmdReady !== 1'b1 && n < 500) begin
			@(negedge clk_sys);
			n++;
		end
		@(negedge clk_sys);
		cmdValid = 1'b0;
		while (rspValid !== 1'b1 && n < 1000) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 1000) begin
			errors++;
			test_done();
		end
		rData = rspData;
		rRef = rspRefused;
		`CHK(rRef, x)
	endtask
	task automatic rd(logic [8:0] rr, cc);
		go(OP_READ, rr, cc, 8'h00, 8'h00, 1'b0, 1'b0);
		`CHK(rData, shadow[rr*512+cc])
	endtask
	initial begin
		seed = 64442;
		resetn = 1'b0;
		cmdValid = 1'b0;
		cmd = '0;
		repeat (5) @(negedge clk_sys);
		resetn = 1'b1;
		// Fills before any colour load must be refused without pin activity.
		go(OP_FLASH_WRITE, 9'h001, 9'h000, 8'h00, 8'hff, 1'b0, 1'b1);
		go(OP_BLOCK_FILL, 9'h001, 9'h000, 8'h0f, 8'hff, 1'b0, 1'b1);
		$display("refusal test done");
		// Page sequences; the second write reuses the first plane mask.
		repeat (6) begin
			// A due refresh closes an open page, so each sequence starts just after one.
			for (int w = 0; w < 200 && cyc % REFRESH_STEP_INT != 30; w++)
				@(negedge clk_sys);
			r = 9'($random(seed));
			c = 9'($random(seed));
			d = 8'($random(seed));
			m = 8'($random(seed));
			put(r, c, d, 8'hff);
			go(OP_WRITE, r, c, d, 8'h00, 1'b1, 1'b0);
			go(OP_LOAD_COLOR, r, c, d, 8'h00, 1'b1, 1'b1);
			rd(r, c);
			put(r, c, ~d, m);
			put(r, c ^ 9'h001, d, m);
			go(OP_MASKED_WRITE, r, c, ~d, m, 1'b1, 1'b0);
			go(OP_WRITE, r, c ^ 9'h001, d, 8'h00, 1'b0, 1'b0);
			rd(r, c);
			rd(r, c ^ 9'h001);
		end
		$display("page test done");
		// Colour load, then plain and plane-masked block fills.
		d = 8'($random(seed));
		go(OP_LOAD_COLOR, 9'h000, 9'h000, d, 8'h00, 1'b0, 1'b0);
		for (int k = 0; k < 2; k++) begin
			r = 9'($random(seed));
			c = 9'($random(seed));
			e = 8'($random(seed));
			m = k ? 8'($random(seed)) : 8'hff;
			for (int i = 0; i < 4; i++)
				if (e[i])
					put(r, {c[8:2], 2'(i)}, d, m);
			go(k ? OP_PLANE_BLOCK : OP_BLOCK_FILL, r, c, e, m, 1'b0, 1'b0);
			for (int i = 0; i < 4; i++)
				rd(r, {c[8:2], 2'(i)});
		end
		$display("block fill test done");
		// Whole row flash under a fresh mask, checked at both ends.
		r = 9'($random(seed));
		m = 8'($random(seed));
		for (int i = 0; i < ROW_COUNT; i++)
			put(r, i, d, m);
		go(OP_FLASH_WRITE, r, 9'h000, 8'h00, m, 1'b0, 1'b0);
		rd(r, 9'h000);
		rd(r, 9'h1ff);
		$display("flash test done");
		// Row to buffer and back under a mask; the upper half first, so the flag must move.
		for (int k = 0; k < 2; k++) begin
			r2 = r + 9'h001;
			c = {~k[0], 8'($random(seed))};
			m = 8'($random(seed));
			go(OP_ROW_TO_BUFFER, r, c, 8'h00, 8'h00, 1'b0, 1'b0);
			repeat (5) @(negedge clk_sys);
			`CHK(halfFlag, c[8])
			for (int i = 0; i < ROW_COUNT; i++)
				put(r2, i, shadow[r*512+i], m);
			go(OP_BUFFER_TO_ROW, r2, c, 8'h00, m, 1'b0, 1'b0);
			rd(r2, c);
		end
		$display("transfer test done");
		// Idle time lets the distributed refresh run.
		repeat (400) @(negedge clk_sys);
		$display("refresh test done");
		test_done();
	end
endmodule

/* verilog/vdram_ctrl.sv */
// How it works
// - Row held open lets further column cycles of any page kind follow.
// - Plane-masked block fill re-supplies mask at every row strobe fall.
// - Flash needs a prior colour load and fresh mask each time.
// - All 512 rows refreshed within every 8 ms, here distributed.
// - Row-only refresh strobes a row with column strobe kept high.
// - Row-to-buffer completion edge aligned with a shift clock rise.
`timescale 1ns/1ps
module vdram_ctrl
	import vdram_ctrl_pkg::*;
(
	// Clock and reset.
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	// User request port.
	input  wire logic              cmdValid,
	input  wire cmd_t              cmd,
	output logic                   cmdReady,
	// User answer port.
	output logic                   rspValid,
	output logic                   rspRefused,
	output logic [DATA_W-1:0]      rspData,
	output logic                   halfFlag,
	// Device pins.
	output logic                   rasN,
	output logic                   casN,
	output logic                   xferOutenN,
	output logic                   writeMaskWeN,
	output logic                   specialFunctionSelect,
	output logic                   shiftClock,
	output logic [ADDR_W-1:0]      addr,
	output logic [DATA_W-1:0]      dqOut,
	output logic                   dqOe,
	input  wire logic [DATA_W-1:0] dqIn,
	input  wire logic              activeHalfFlag
);

	typedef struct packed {
		fsm_t              fsm;
		pins_t             pins;
		cmd_t              cur;
		logic              isRefresh;
		logic [1:0]        cnt;
		logic [7:0]        refTimer;
		logic              refPending;
		logic [ADDR_W-1:0] refRow;
		logic              colorLoaded;
		logic              cmdReady;
		logic              rspValid;
		logic              rspRefused;
		logic [DATA_W-1:0] rspData;
		logic [DATA_W-1:0] dqSync1;
		logic [DATA_W-1:0] dqSync2;
		logic              halfSync1;
		logic              halfSync2;
		logic              halfFlag;
	} state_t;

	state_t s;
	state_t next_s;

	// Ops that need the colour register already loaded.
	function automatic logic needsColor(input op_t op);
		needsColor = (op == OP_BLOCK_FILL) || (op == OP_PLANE_BLOCK) || (op == OP_FLASH_WRITE);
	endfunction

	// Ops that may run as further column cycles of an open row.
	function automatic logic pageOp(input op_t op);
		pageOp = (op == OP_READ) || (op == OP_WRITE) || (op == OP_MASKED_WRITE)
			|| (op == OP_BLOCK_FILL) || (op == OP_PLANE_BLOCK);
	endfunction

	// Next-state logic for the whole controller.
	always_comb begin
		next_s = s;
		next_s.rspValid = 1'b0;
		next_s.pins.shiftClock = 1'b0;
		// Pin inputs cross into the clock domain through two stages.
		next_s.dqSync1 = dqIn;
		next_s.dqSync2 = s.dqSync1;
		next_s.halfSync1 = activeHalfFlag;
		next_s.halfSync2 = s.halfSync1;
		next_s.halfFlag = s.halfSync2;

		case (s.fsm)
			ST_IDLE: begin
				if (s.cmdReady && cmdValid) begin
					next_s.cur = cmd;
					next_s.isRefresh = 1'b0;
					if (needsColor(cmd.op) && !s.colorLoaded) begin
						next_s.rspValid = 1'b1;
						next_s.rspRefused = 1'b1;
					end else begin
						next_s.rspRefused = 1'b0;
						next_s.fsm = ST_RAS_SET;
					end
				end else if (s.refPending) begin
					next_s.isRefresh = 1'b1;
					next_s.refPending = 1'b0;
					next_s.fsm = ST_RAS_SET;
				end
			end
			ST_RAS_SET: begin
				// Levels set here are stable one cycle before the row strobe falls.
				next_s.pins.casN = 1'b1;
				next_s.pins.xferOutenN = 1'b1;
				next_s.pins.writeMaskWeN = 1'b1;
				next_s.pins.specialFunctionSelect = 1'b0;
				next_s.pins.dqOe = 1'b0;
				next_s.pins.dqOut = s.cur.mask;
				if (s.isRefresh) begin
					next_s.pins.addr = s.refRow;
				end else begin
					next_s.pins.addr = s.cur.row;
					case (s.cur.op)
						OP_MASKED_WRITE, OP_PLANE_BLOCK: begin
							next_s.pins.writeMaskWeN = 1'b0;
							next_s.pins.dqOe = 1'b1;
						end
						OP_LOAD_COLOR: begin
							next_s.pins.specialFunctionSelect = 1'b1;
						end
						OP_FLASH_WRITE: begin
							next_s.pins.writeMaskWeN = 1'b0;
							next_s.pins.specialFunctionSelect = 1'b1;
							next_s.pins.dqOe = 1'b1;
						end
						OP_ROW_TO_BUFFER: begin
							next_s.pins.xferOutenN = 1'b0;
						end
						OP_BUFFER_TO_ROW: begin
							next_s.pins.xferOutenN = 1'b0;
							next_s.pins.writeMaskWeN = 1'b0;
							next_s.pins.dqOe = 1'b1;
						end
						default: begin
						end
					endcase
				end
				next_s.fsm = ST_RAS_ACT;
			end
			ST_RAS_ACT: begin
				next_s.pins.rasN = 1'b0;
				next_s.fsm = s.isRefresh ? ST_CAS_END : ST_COL_SET;
			end
			ST_COL_SET: begin
				// Early write: write enable drops before the column strobe.
				next_s.pins.addr = s.cur.col;
				next_s.pins.dqOut = s.cur.data;
				next_s.pins.dqOe = 1'b0;
				next_s.pins.specialFunctionSelect = 1'b0;
				next_s.cnt = 2'h0;
				case (s.cur.op)
					OP_READ: begin
						next_s.pins.xferOutenN = 1'b0;
					end
					OP_WRITE, OP_MASKED_WRITE, OP_LOAD_COLOR: begin
						next_s.pins.writeMaskWeN = 1'b0;
						next_s.pins.dqOe = 1'b1;
					end
					OP_BLOCK_FILL, OP_PLANE_BLOCK: begin
						next_s.pins.specialFunctionSelect = 1'b1;
						next_s.pins.writeMaskWeN = 1'b0;
						next_s.pins.dqOe = 1'b1;
						next_s.pins.addr[BLOCK_COL_LSB-1:0] = 2'h0;
					end
					default: begin
					end
				endcase
				next_s.fsm = ST_CAS_ACT;
			end
			ST_CAS_ACT: begin
				next_s.pins.casN = 1'b0;
				next_s.cnt = s.cnt + 2'h1;
				if (s.cnt == CAS_LOW_CYCLES) begin
					next_s.rspValid = 1'b1;
					next_s.rspData = s.dqSync2;
					next_s.fsm = ST_CAS_END;
				end
			end
			ST_CAS_END: begin
				next_s.pins.casN = 1'b1;
				next_s.pins.writeMaskWeN = 1'b1;
				next_s.pins.specialFunctionSelect = 1'b0;
				next_s.pins.dqOe = 1'b0;
				next_s.pins.xferOutenN = 1'b1;
				next_s.pins.shiftClock = !s.isRefresh && (s.cur.op == OP_ROW_TO_BUFFER);
				if (!s.isRefresh && (s.cur.op == OP_LOAD_COLOR)) begin
					next_s.colorLoaded = 1'b1;
				end
				if (s.isRefresh) begin
					next_s.refRow = s.refRow + 9'h001;
				end
				if (!s.isRefresh && s.cur.keepOpen && pageOp(s.cur.op) && !s.refPending) begin
					next_s.fsm = ST_PAGE_OPEN;
				end else begin
					next_s.pins.rasN = 1'b1;
					next_s.fsm = ST_PRECHARGE;
				end
			end
			ST_PAGE_OPEN: begin
				if (s.cmdReady && cmdValid) begin
					if (!pageOp(cmd.op) || (needsColor(cmd.op) && !s.colorLoaded)) begin
						next_s.rspValid = 1'b1;
						next_s.rspRefused = 1'b1;
					end else begin
						next_s.cur = cmd;
						next_s.cur.row = s.cur.row;
						next_s.rspRefused = 1'b0;
						next_s.fsm = ST_COL_SET;
					end
				end else if (s.refPending) begin
					// A due refresh closes the page so rows are not starved.
					next_s.pins.rasN = 1'b1;
					next_s.fsm = ST_PRECHARGE;
				end
			end
			ST_PRECHARGE: begin
				next_s.fsm = ST_IDLE;
			end
			default: begin
				next_s.fsm = ST_IDLE;
			end
		endcase

		if (s.refTimer == REFRESH_STEP_CYCLES - 8'h01) begin
			next_s.refTimer = 8'h00;
			next_s.refPending = 1'b1;
		end else begin
			next_s.refTimer = s.refTimer + 8'h01;
		end

		// Ready is registered, so it is worked out from the next state.
		next_s.cmdReady = ((next_s.fsm == ST_IDLE) || (next_s.fsm == ST_PAGE_OPEN))
			&& !next_s.refPending;
	end

	// State register with synchronous reset.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s <= '0;
			s.fsm <= ST_IDLE;
			s.pins.rasN <= 1'b1;
			s.pins.casN <= 1'b1;
			s.pins.xferOutenN <= 1'b1;
			s.pins.writeMaskWeN <= 1'b1;
			s.refRow <= REFRESH_ROW_RESET;
			s.refTimer <= REFRESH_TIMER_RESET;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register.
	assign cmdReady              = s.cmdReady;
	assign rspValid              = s.rspValid;
	assign rspRefused            = s.rspRefused;
	assign rspData               = s.rspData;
	assign halfFlag              = s.halfFlag;
	assign rasN                  = s.pins.rasN;
	assign casN                  = s.pins.casN;
	assign xferOutenN            = s.pins.xferOutenN;
	assign writeMaskWeN          = s.pins.writeMaskWeN;
	assign specialFunctionSelect = s.pins.specialFunctionSelect;
	assign shiftClock            = s.pins.shiftClock;
	assign addr                  = s.pins.addr;
	assign dqOut                 = s.pins.dqOut;
	assign dqOe                  = s.pins.dqOe;

endmodule

/* verilog/vdram_ctrl_pkg.sv */
package vdram_ctrl_pkg;

	// Array geometry.
	localparam int ROW_COUNT = 512;
	localparam int ADDR_W    = 9;
	localparam int DATA_W    = 8;

	// Refresh spacing: every row once per interval, spread evenly; rounded down.
	localparam int REFRESH_INTERVAL_MS = 8;
	localparam int CLK_PERIOD_NS       = 100;
	localparam int REFRESH_STEP_INT    =
		(REFRESH_INTERVAL_MS * 1000000) / (ROW_COUNT * CLK_PERIOD_NS);
	localparam logic [7:0] REFRESH_STEP_CYCLES = 8'(REFRESH_STEP_INT);

	// Last count of the column strobe low phase, so the strobe stays low four cycles; covers two synchroniser stages.
	localparam logic [1:0] CAS_LOW_CYCLES = 2'h3;

	// Reset values.
	localparam logic [ADDR_W-1:0] REFRESH_ROW_RESET = 9'h000;
	localparam logic [7:0]        REFRESH_TIMER_RESET = 8'h00;

	// Block fill ignores the two lowest column bits.
	localparam int BLOCK_COL_LSB = 2;

	// Operations a user may request.
	typedef enum logic [3:0] {
		OP_READ          = 4'h0,
		OP_WRITE         = 4'h1,
		OP_MASKED_WRITE  = 4'h2,
		OP_BLOCK_FILL    = 4'h3,
		OP_PLANE_BLOCK   = 4'h4,
		OP_LOAD_COLOR    = 4'h5,
		OP_FLASH_WRITE   = 4'h6,
		OP_ROW_TO_BUFFER = 4'h7,
		OP_BUFFER_TO_ROW = 4'h8
	} op_t;

	// One user request.
	typedef struct packed {
		op_t               op;
		logic [ADDR_W-1:0] row;
		logic [ADDR_W-1:0] col;
		logic [DATA_W-1:0] data;     // Write data, colour, or column enables in [3:0].
		logic [DATA_W-1:0] mask;     // Plane mask, one bit per plane.
		logic              keepOpen; // Leave the row open for page accesses.
	} cmd_t;

	// Levels driven onto the device pins.
	typedef struct packed {
		logic              rasN;
		logic              casN;
		logic              xferOutenN;
		logic              writeMaskWeN;
		logic              specialFunctionSelect;
		logic              shiftClock;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dqOut;
		logic              dqOe;
	} pins_t;

	typedef enum logic [2:0] {
		ST_IDLE      = 3'h0,
		ST_RAS_SET   = 3'h1,
		ST_RAS_ACT   = 3'h2,
		ST_COL_SET   = 3'h3,
		ST_CAS_ACT   = 3'h4,
		ST_CAS_END   = 3'h5,
		ST_PAGE_OPEN = 3'h6,
		ST_PRECHARGE = 3'h7
	} fsm_t;

endpackage
